// ### bench/busy_line_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Shared busy line of the daisy-chained control bus.
// ****************************************************************
// Wired-OR of this board's driver and the busy of the other boards.
module busy_line_model (
    input wire logic own_busy_i,
    input wire logic own_oe_n_i,
    input wire logic others_busy_i,
    output logic line_o
);
    // A released driver adds nothing; any board pulling makes the line high.
    assign line_o = (~own_oe_n_i & own_busy_i) | others_busy_i;
endmodule : busy_line_model

// ### bench/test_front_panel_status.sv
`timescale 1ns/1ns
// ****************************************************************
// Self-checking bench of the front panel status logic.
// ****************************************************************
module test_front_panel_status;
    localparam int unsigned ACK = 4; // Short flash so the run stays brief.
    localparam int unsigned CFG = 8; // Short configuration display.
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic acc = 1'b0;
    logic [3:0] cause = 4'h0; // Converting, analog reset, memory test, store full.
    logic nz = 1'b0;
    logic [6:0] tp = 7'h00;
    logic [6:0] tn = 7'h00;
    logic ovc = 1'b0;
    logic jmp = 1'b0;
    logic others = 1'b0; // Busy of the other chained boards.
    logic line, bus_o, oe_n, halt, ack_led, busy_led, ev_led, irq;
    logic [1:0] term_led, pwr_led;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic irq_a;
    int n_mismatch = 0;
    int compares = 0;

    // The clock toggles every 10 ns, half of its 20 ns period.
    initial begin
        forever #10 clk_i = ~clk_i;
    end

    front_panel_status #(.ACK_CYC(ACK), .CFG_CYC(CFG), .LINES(7)) front_panel_status_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_access_i(acc),
        .converting_i(cause[3]), .analog_reset_i(cause[2]), .mem_test_i(cause[1]),
        .multi_event_store_full_i(cause[0]), .event_count_nz_i(nz),
        .term_pos_i(tp), .term_neg_i(tn), .overcurrent_i(ovc),
        .busy_scope_jumper_i(jmp), .busy_bus_i(line), .busy_bus_o(bus_o),
        .busy_bus_oe_n_o(oe_n), .acq_halt_o(halt), .ack_led_o(ack_led),
        .busy_led_o(busy_led), .event_available_led_o(ev_led), .term_led_o(term_led),
        .power_overcurrent_led_o(pwr_led), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq)
    );

    busy_line_model busy_line_model_i (
        .own_busy_i(bus_o), .own_oe_n_i(oe_n), .others_busy_i(others), .line_o(line)
    );

    // Compares one value and reports a difference at once.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Lets registered outputs follow the inputs driven at the last edge.
    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask : settle

    // One-cycle register write.
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : reg_wr

    // One-cycle register read; data are judged in the cycle after the strobe.
    // The read port must fall back to zero one cycle later.
    task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
        @(posedge clk_i);
        #1;
        chk(rdata, 8'h00);
    endtask : reg_rd

    // Configuration display, then the plain lamps once it is over.
    task automatic t_config();
        chk(busy_led, 1'b1);
        chk(ev_led, 1'b1);
        chk(term_led, panel_pkg::LED_ORANGE);
        chk(pwr_led, panel_pkg::LED_GREEN);
        repeat (CFG + 3) @(posedge clk_i);
        #1;
        chk(busy_led, 1'b0);
        chk(term_led, panel_pkg::LED_RED);
    endtask : t_config

    // Each busy cause alone lights the lamp and pulls the shared line.
    task automatic t_busy();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            cause <= 4'h8 >> i;
            settle();
            chk(busy_led, 1'b1);
            chk(bus_o, 1'b1);
            chk(oe_n, 1'b0);
            @(posedge clk_i);
            cause <= 4'h0;
            settle();
            chk(busy_led, 1'b0);
        end
    endtask : t_busy

    // Sets the termination switches and judges the lamp.
    task automatic term_case(input logic [6:0] p, input logic [6:0] n, input logic [1:0] e);
        @(posedge clk_i);
        tp <= p;
        tn <= n;
        settle();
        chk(term_led, e);
    endtask : term_case

    // Termination, data and power lamps.
    task automatic t_lamps();
        term_case(7'h7F, 7'h7F, panel_pkg::LED_GREEN);
        term_case(7'h7F, 7'h00, panel_pkg::LED_RED);
        term_case(7'h01, 7'h01, panel_pkg::LED_OFF);
        term_case(7'h00, 7'h00, panel_pkg::LED_RED);
        @(posedge clk_i);
        nz <= 1'b1;
        ovc <= 1'b1;
        settle();
        chk(ev_led, 1'b1);
        chk(pwr_led, panel_pkg::LED_ORANGE);
        @(posedge clk_i);
        nz <= 1'b0;
        ovc <= 1'b0;
        settle();
        chk(ev_led, 1'b0);
        chk(pwr_led, panel_pkg::LED_GREEN);
    endtask : t_lamps

    // Halt follows the bus busy or only the own busy, per jumper.
    task automatic t_halt();
        @(posedge clk_i);
        others <= 1'b1;
        jmp <= 1'b1;
        settle();
        chk(halt, 1'b1);
        @(posedge clk_i);
        jmp <= 1'b0;
        settle();
        chk(halt, 1'b0);
        @(posedge clk_i);
        others <= 1'b0;
        cause <= 4'h8;
        settle();
        chk(halt, 1'b1);
        reg_rd(panel_pkg::OFS_STATUS, 8'h09);
        @(posedge clk_i);
        cause <= 4'h0;
        settle();
        chk(halt, 1'b0);
    endtask : t_halt

    // A single access flash is stretched, then goes out.
    task automatic t_ack();
        @(posedge clk_i);
        acc <= 1'b1;
        @(posedge clk_i);
        acc <= 1'b0;
        #1;
        chk(ack_led, 1'b1);
        repeat (ACK - 2) @(posedge clk_i);
        #1;
        chk(ack_led, 1'b1);
        repeat (4) @(posedge clk_i);
        #1;
        chk(ack_led, 1'b0);
    endtask : t_ack

    // Sticky event bit, mask effect on the line, clear by a one, unmapped read.
    task automatic t_regs();
        reg_wr(panel_pkg::OFS_IRQ_STAT, 8'h0F);
        reg_rd(panel_pkg::OFS_IRQ_STAT, 8'h00);
        @(posedge clk_i);
        nz <= 1'b1;
        settle();
        reg_rd(panel_pkg::OFS_IRQ_STAT, 8'h02);
        reg_wr(panel_pkg::OFS_IRQ_MASK, 8'h00);
        settle();
        irq_a = irq;
        reg_wr(panel_pkg::OFS_IRQ_MASK, 8'h0F);
        settle();
        chk(irq_a ^ irq, 1'b1);
        reg_wr(panel_pkg::OFS_IRQ_STAT, 8'h02);
        reg_rd(panel_pkg::OFS_IRQ_STAT, 8'h00);
        #1;
        chk(irq, 1'b0);
        reg_rd(4'hF, 8'h00);
        // A new data event in the same cycle as its clear must stay set.
        @(posedge clk_i);
        nz <= 1'b0;
        settle();
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= panel_pkg::OFS_IRQ_STAT;
        wdata <= 8'h02;
        nz <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
        reg_rd(panel_pkg::OFS_IRQ_STAT, 8'h02);
    endtask : t_regs

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // Cuts a hang short well beyond the roughly 120 cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        results();
    end

    // Main sequence: reset for six cycles, then every scenario in turn.
    initial begin
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1;
        t_config();
        t_busy();
        t_lamps();
        t_halt();
        t_ack();
        t_regs();
        results();
    end
endmodule : test_front_panel_status

// ### design/front_panel_status.sv
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ns
//
// Contract
// (RULE_01) Green acknowledge lamp flashes on each access.
// (RULE_02) Red busy: converting, resetting, memtest, store full.
// (RULE_03) Yellow lamp lit when output holds events.
// (RULE_04) Termination lamp green all, red none, else off.
// (RULE_05) Configuring: busy, data lamps on, termination orange.
// (RULE_06) Power lamp green, orange on over-current.
// (RULE_07) Line terminated only with both switches set.
// (RULE_08) Jumper high: halt on shared bus busy.
// (RULE_09) Jumper low: halt on own busy only.
// (RULE_10) Drive own busy onto wired-OR bus line.
// (RULE_11) Stretch access flash to visible length.
//
module front_panel_status #(
    parameter int unsigned ACK_CYC = panel_pkg::ACK_FLASH_CYC,
    parameter int unsigned CFG_CYC = panel_pkg::CONFIG_CYC,
    parameter int unsigned LINES = panel_pkg::CTRL_LINES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic bus_access_i,
    input wire logic converting_i,
    input wire logic analog_reset_i,
    input wire logic mem_test_i,
    input wire logic multi_event_store_full_i,
    input wire logic event_count_nz_i,
    input wire logic [LINES-1:0] term_pos_i,
    input wire logic [LINES-1:0] term_neg_i,
    input wire logic overcurrent_i,
    input wire logic busy_scope_jumper_i,
    input wire logic busy_bus_i,
    output logic busy_bus_o,
    output logic busy_bus_oe_n_o,
    output logic acq_halt_o,
    output logic ack_led_o,
    output logic busy_led_o,
    output logic event_available_led_o,
    output logic [1:0] term_led_o,
    output logic [1:0] power_overcurrent_led_o,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic irq_o
);

    // ****************************************
    // Local functions and signals
    // ****************************************

    // Counter width large enough for the longer of the two timers.
    localparam int unsigned CW = $clog2((ACK_CYC > CFG_CYC ? ACK_CYC : CFG_CYC) + 1);

    // Returns the number of lines whose positive and negative switches are both set.
    function automatic int unsigned count_term(input logic [LINES-1:0] p,
                                               input logic [LINES-1:0] n);
        int unsigned c;
        c = 0;
        for (int unsigned k = 0; k < LINES; k++) begin
            if (p[k] && n[k]) begin // RULE_07
                c = c + 1;
            end
        end
        return c;
    endfunction : count_term

    panel_pkg::phase_t phase_r; // Configuration or normal running.
    logic [CW-1:0] cfg_cnt_r; // Cycles left of the configuration display.
    logic [CW-1:0] ack_cnt_r; // Cycles left of the access flash.
    logic own_busy; // The module's own busy condition.
    logic halt_now; // Acquisition halt decision.
    logic [LINES-1:0] term_line; // Per-line termination state.
    logic [panel_pkg::IRQ_W-1:0] irq_stat_r; // Sticky event flags.
    logic [panel_pkg::IRQ_W-1:0] irq_mask_r; // Interrupt enables.
    logic [panel_pkg::IRQ_W-1:0] irq_ev; // Event pulses this cycle.
    logic own_busy_q; // Previous own busy, for edge detection.
    logic data_q; // Previous data-ready level.
    logic ovc_q; // Previous over-current level.
    logic halt_q; // Previous halt level.

    // ****************************************
    // Busy logic
    // ****************************************

    // Own busy is the OR of the four internal causes.
    assign own_busy = converting_i | analog_reset_i | mem_test_i | multi_event_store_full_i; // RULE_02

    // Busy is pulled onto the shared line when set; the enable is low while driving.
    assign busy_bus_o = own_busy; // RULE_10
    assign busy_bus_oe_n_o = ~own_busy; // RULE_10

    // The jumper picks the bus-wide or the local busy as the halt source.
    assign halt_now = busy_scope_jumper_i ? (busy_bus_i | own_busy) // RULE_08
                                          : own_busy; // RULE_09

    // Halt output is registered.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            acq_halt_o <= 1'b0;
        end else begin
            acq_halt_o <= halt_now; // RULE_08 RULE_09
        end
    end

    // ****************************************
    // Power-on configuration phase
    // ****************************************

    // After reset the panel shows the configuring pattern for a fixed time.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            phase_r <= panel_pkg::PH_CONFIG;
            cfg_cnt_r <= CW'(CFG_CYC - 1);
        end else begin
            case (phase_r)
                panel_pkg::PH_CONFIG: begin
                    // Count down and leave when the time has run out.
                    if (cfg_cnt_r == '0) begin
                        phase_r <= panel_pkg::PH_RUN;
                    end else begin
                        cfg_cnt_r <= cfg_cnt_r - 1'b1;
                    end
                end
                panel_pkg::PH_RUN: begin
                    // Stay running until the next reset.
                    phase_r <= panel_pkg::PH_RUN;
                end
                default: begin
                    phase_r <= panel_pkg::PH_RUN;
                end
            endcase
        end
    end

    // ****************************************
    // Access flash stretcher
    // ****************************************

    // Each access reloads the counter so even one cycle stays visible.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ack_cnt_r <= '0;
        end else if (bus_access_i) begin
            ack_cnt_r <= CW'(ACK_CYC); // RULE_11
        end else if (ack_cnt_r != '0) begin
            ack_cnt_r <= ack_cnt_r - 1'b1;
        end
    end

    // ****************************************
    // Indicator drivers
    // ****************************************

    // All lamps are registered; configuration overrides the busy, data and termination lamps.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ack_led_o <= 1'b0;
            busy_led_o <= 1'b1;
            event_available_led_o <= 1'b1;
            term_led_o <= panel_pkg::LED_ORANGE;
            power_overcurrent_led_o <= panel_pkg::LED_GREEN;
        end else begin
            ack_led_o <= bus_access_i || (ack_cnt_r != '0); // RULE_01
            // Power lamp is independent of configuration.
            power_overcurrent_led_o <= overcurrent_i ? panel_pkg::LED_ORANGE // RULE_06
                                                     : panel_pkg::LED_GREEN;
            if (phase_r == panel_pkg::PH_CONFIG) begin
                busy_led_o <= 1'b1; // RULE_05
                event_available_led_o <= 1'b1; // RULE_05
                term_led_o <= panel_pkg::LED_ORANGE; // RULE_05
            end else begin
                busy_led_o <= own_busy; // RULE_02
                event_available_led_o <= event_count_nz_i; // RULE_03
                // Green for all lines, red for none, dark otherwise.
                if (count_term(term_pos_i, term_neg_i) == LINES) begin
                    term_led_o <= panel_pkg::LED_GREEN; // RULE_04
                end else if (count_term(term_pos_i, term_neg_i) == 0) begin
                    term_led_o <= panel_pkg::LED_RED; // RULE_04
                end else begin
                    term_led_o <= panel_pkg::LED_OFF; // RULE_04
                end
            end
        end
    end

    // ****************************************
    // Interrupt events
    // ****************************************

    // Remember the previous levels to catch rising edges.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            own_busy_q <= 1'b0;
            data_q <= 1'b0;
            ovc_q <= 1'b0;
            halt_q <= 1'b0;
        end else begin
            own_busy_q <= own_busy;
            data_q <= event_count_nz_i;
            ovc_q <= overcurrent_i;
            halt_q <= halt_now;
        end
    end

    // Rising edges of busy, data ready, over-current and halt are events.
    always_comb begin
        irq_ev = '0;
        irq_ev[panel_pkg::BIT_BUSY] = own_busy & ~own_busy_q;
        irq_ev[panel_pkg::BIT_DATA] = event_count_nz_i & ~data_q;
        irq_ev[panel_pkg::BIT_OVC] = overcurrent_i & ~ovc_q;
        irq_ev[panel_pkg::BIT_HALT] = halt_now & ~halt_q;
    end

    // Sticky flags; a new event wins over a write-one-to-clear.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_stat_r <= '0;
        end else begin
            if (reg_wr_i && reg_addr_i == panel_pkg::OFS_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~reg_wdata_i[panel_pkg::IRQ_W-1:0]) | irq_ev;
            end else begin
                irq_stat_r <= irq_stat_r | irq_ev;
            end
        end
    end

    // Mask register written by software.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_mask_r <= '0;
        end else if (reg_wr_i && reg_addr_i == panel_pkg::OFS_IRQ_MASK) begin
            irq_mask_r <= reg_wdata_i[panel_pkg::IRQ_W-1:0];
        end
    end

    // Level interrupt while any unmasked flag is set.
    assign irq_o = |(irq_stat_r & irq_mask_r);

    // ****************************************
    // Register read port
    // ****************************************

    // Read data stand in the cycle after the strobe only.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                panel_pkg::OFS_STATUS: begin
                    reg_rdata_o <= '0;
                    reg_rdata_o[panel_pkg::BIT_BUSY] <= own_busy;
                    reg_rdata_o[panel_pkg::BIT_DATA] <= event_count_nz_i;
                    reg_rdata_o[panel_pkg::BIT_OVC] <= overcurrent_i;
                    reg_rdata_o[panel_pkg::BIT_HALT] <= acq_halt_o;
                    reg_rdata_o[panel_pkg::BIT_CFG] <= (phase_r == panel_pkg::PH_CONFIG);
                end
                panel_pkg::OFS_IRQ_STAT: begin
                    reg_rdata_o <= 8'(irq_stat_r);
                end
                panel_pkg::OFS_IRQ_MASK: begin
                    reg_rdata_o <= 8'(irq_mask_r);
                end
                default: begin
                    reg_rdata_o <= '0;
                end
            endcase
        end else begin
            reg_rdata_o <= '0;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************

    // Busy lamp follows own busy one cycle later once running.
    busy_lamp_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        phase_r == panel_pkg::PH_RUN |=> busy_led_o == $past(own_busy)) // RULE_02
        else $error("busy lamp wrong");

    // Data lamp follows the event level once running.
    data_lamp_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        phase_r == panel_pkg::PH_RUN |=> event_available_led_o == $past(event_count_nz_i)) // RULE_03
        else $error("data lamp wrong");

    // An access lights the lamp and it stays lit for the next two cycles.
    ack_flash_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        bus_access_i |=> ack_led_o [*2]) // RULE_01 RULE_11
        else $error("access lamp too short");

    // Partial termination leaves the lamp dark.
    term_partial_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (phase_r == panel_pkg::PH_RUN && (term_pos_i & term_neg_i) != '0
         && (term_pos_i & term_neg_i) != '1) |=> term_led_o == panel_pkg::LED_OFF) // RULE_04 RULE_07
        else $error("term lamp wrong");

    // Configuring shows the orange termination pattern.
    config_show_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $past(phase_r) == panel_pkg::PH_CONFIG |-> term_led_o == panel_pkg::LED_ORANGE
                                                   && busy_led_o && event_available_led_o) // RULE_05
        else $error("config pattern wrong");

    // Over-current turns the power lamp orange next cycle.
    power_lamp_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        overcurrent_i |=> power_overcurrent_led_o == panel_pkg::LED_ORANGE) // RULE_06
        else $error("power lamp wrong");

    // Jumper high: bus busy halts acquisition.
    halt_bus_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        busy_scope_jumper_i && busy_bus_i |=> acq_halt_o) // RULE_08
        else $error("bus busy ignored");

    // Jumper low: only own busy halts acquisition.
    halt_own_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !busy_scope_jumper_i |=> acq_halt_o == $past(own_busy)) // RULE_09
        else $error("own halt wrong");

    // Bus line driven exactly while busy.
    bus_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        busy_bus_oe_n_o == !(converting_i || analog_reset_i || mem_test_i
                             || multi_event_store_full_i)) // RULE_10
        else $error("bus drive wrong");

endmodule : front_panel_status

// ### pkg/panel_pkg.sv
package panel_pkg;

    // Clock rate of the module clock in hertz.
    localparam int unsigned CLK_HZ = 50_000_000;
    // Least visible time of a bus-access flash, in milliseconds.
    localparam int unsigned ACK_FLASH_MS = 50;
    // Cycles that one bus-access flash lasts.
    localparam int unsigned ACK_FLASH_CYC = (CLK_HZ / 1000) * ACK_FLASH_MS;
    // Length of the power-on configuration display, in milliseconds.
    localparam int unsigned CONFIG_MS = 500;
    // Cycles that the power-on configuration display lasts.
    localparam int unsigned CONFIG_CYC = (CLK_HZ / 1000) * CONFIG_MS;
    // Number of control bus lines with termination switch pairs.
    localparam int unsigned CTRL_LINES = 7;

    // Register offsets of the plain register port.
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h1;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h2;

    // Bit positions in the live status word and the interrupt registers.
    localparam int unsigned BIT_BUSY = 0;
    localparam int unsigned BIT_DATA = 1;
    localparam int unsigned BIT_OVC = 2;
    localparam int unsigned BIT_HALT = 3;
    localparam int unsigned BIT_CFG = 4;
    // Width of the interrupt status and mask registers.
    localparam int unsigned IRQ_W = 4;

    // Two-colour indicator codes: bit 0 lights the green die, bit 1 the red die.
    localparam logic [1:0] LED_OFF = 2'h0;
    localparam logic [1:0] LED_GREEN = 2'h1;
    localparam logic [1:0] LED_RED = 2'h2;
    localparam logic [1:0] LED_ORANGE = 2'h3;

    // Phases of the panel after power-on.
    typedef enum logic [0:0] {
        PH_CONFIG,
        PH_RUN
    } phase_t;

endpackage : panel_pkg
